// ---- core/id_regs_pkg.sv ----
// constants for the identification register bank
// How it works
// - four identification words live in the extended special register space.
// - all four words are read only; writes never change them.
// - maker word holds maker code above a fixed five-bit 00011 pattern.
// - chip word holds a twelve-bit device code above a revision nibble.
// - memory word: type in bits 15..12, size below, capacity four times size.
// - type codes: 0 none, 1 ROM, 2 standard flash, 3 fast flash.
// - after init the size reads 0d0h (832 Kbyte) and type fast flash.
// - supply byte in bits 7..0 reads 40h, meaning 5 V.
// - programming descriptor upper byte reads zero: no external high voltage.
// - fields are guaranteed only once flash initialization has completed.
// - boot select high at the first edge after reset release means init done, words ready immediately.
// - software polls bits 15 and 14 of memory word; cleared when init done.
// - before init memory word reads f0d0h, programming word reads 0040h.
package id_regs_pkg;
    // =========================================================
    // addresses
    localparam logic [15:0] ADDR_PROG  = 16'hf078;
    localparam logic [15:0] ADDR_MEM   = 16'hf07a;
    localparam logic [15:0] ADDR_CHIP  = 16'hf07c;
    localparam logic [15:0] ADDR_MAKER = 16'hf07e;
    // =========================================================
    // field layout and values
    localparam int          MAKER_LSB      = 5;
    localparam logic [4:0]  MAKER_PATTERN  = 5'h03;
    localparam int          CHIP_LSB       = 4;
    localparam int          TYPE_LSB       = 12;
    localparam logic [3:0]  TYPE_NONE      = 4'h0;
    localparam logic [3:0]  TYPE_ROM       = 4'h1;
    localparam logic [3:0]  TYPE_STD_FLASH = 4'h2;
    localparam logic [3:0]  TYPE_FAST_FLASH= 4'h3;
    localparam logic [11:0] SIZE_FINAL     = 12'h0d0;
    localparam logic [3:0]  TYPE_PROVISION = 4'hf;
    localparam logic [7:0]  SUPPLY_LEVEL   = 8'h40;
    localparam logic [7:0]  HV_LEVEL       = 8'h00;
    localparam logic [15:0] MEM_PROVISION  = 16'hf0d0;
    localparam logic [15:0] MEM_FINAL      = 16'h30d0;
    localparam logic [15:0] PROG_VALUE     = 16'h0040;
    localparam logic [15:0] RDATA_RESET    = 16'h0000;
endpackage : id_regs_pkg

// ---- core/id_word_mux.sv ----
// read selector over the four identification words
`timescale 1ns/1ps
module id_word_mux
    import id_regs_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [15:0] maker_word,
    input  wire logic [15:0] chip_word,
    input  wire logic [15:0] mem_word,
    input  wire logic [15:0] prog_word,
    output logic             hit,
    output logic      [15:0] word
);
    import id_regs_pkg::*;

    always_comb
    begin
        hit  = 1'b1;
        word = 16'h0000;
        unique case (addr)
            ADDR_MAKER: word = maker_word;
            ADDR_CHIP:  word = chip_word;
            ADDR_MEM:   word = mem_word;
            ADDR_PROG:  word = prog_word;
            default:    hit  = 1'b0;
        endcase
    end
endmodule : id_word_mux

// ---- core/device_identification_registers.sv ----
// identification register bank with flash-init gating
`timescale 1ns/1ps
module device_identification_registers
    import id_regs_pkg::*;
#(
    // arbitrary neutral identity values
    parameter logic [10:0] MAKER_CODE = 11'h155,
    parameter logic [11:0] CHIP_CODE  = 12'h5a5,
    parameter logic [3:0]  REVISION   = 4'h1
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        external_boot_select_pin,
    input  wire logic        flash_init_done,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata,
    output logic             rvalid,
    output logic             addr_hit
);
    import id_regs_pkg::*;

    // =========================================================
    // init state
    logic        ready_q;
    logic        init_ok;
    logic        rst_b_prev_q;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic        hit_q;
    logic        sel_hit;
    logic [15:0] sel_word;
    logic [15:0] maker_word;
    logic [15:0] chip_word;
    logic [15:0] mem_word;
    logic [15:0] prog_word;

    always_ff @(posedge core_clk)
    begin
        rst_b_prev_q <= rst_b;
    end

    // boot pin level caught at the first edge after reset release
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            ready_q <= 1'b0;
        else if (!rst_b_prev_q && external_boot_select_pin)
            ready_q <= 1'b1;
        else if (flash_init_done)
            ready_q <= 1'b1;
    end

    // =========================================================
    // words
    assign maker_word = {MAKER_CODE, MAKER_PATTERN};
    assign chip_word  = {CHIP_CODE, REVISION};
    // strap counts from the first edge: internal boot never reads provisional
    assign init_ok    = ready_q
                      | (!rst_b_prev_q & external_boot_select_pin);
    // provisional word sets both poll bits until init completes
    assign mem_word   = init_ok
                      ? {TYPE_FAST_FLASH, SIZE_FINAL}
                      : MEM_PROVISION;
    assign prog_word  = {HV_LEVEL, SUPPLY_LEVEL};

    id_word_mux u_mux
    (
        .addr       (addr),
        .maker_word (maker_word),
        .chip_word  (chip_word),
        .mem_word   (mem_word),
        .prog_word  (prog_word),
        .hit        (sel_hit),
        .word       (sel_word)
    );

    // =========================================================
    // read port; writes have no path into any word
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rdata_q  <= RDATA_RESET;
            rvalid_q <= 1'b0;
            hit_q    <= 1'b0;
        end
        else
        begin
            rvalid_q <= rd_en;
            hit_q    <= rd_en & sel_hit;
            if (rd_en)
                rdata_q <= sel_word;
        end
    end

    assign rdata    = rdata_q;
    assign rvalid   = rvalid_q;
    assign addr_hit = hit_q;

    // =========================================================
    // checks
    a_mem_provisional: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_MEM && !init_ok
         |=> rdata == MEM_PROVISION)
        else $error("provisional memory word wrong");

    a_mem_final: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_MEM && init_ok
         |=> rdata == MEM_FINAL)
        else $error("final memory word wrong");

    a_poll_bits: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_MEM
         |=> (rdata[15:14] == 2'b00) == $past(init_ok))
        else $error("poll bits disagree with init");

    a_init_latency: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         flash_init_done
         |=> ready_q)
        else $error("init not taken next cycle");

    a_init_sticky: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         ready_q
         |=> ready_q)
        else $error("init state fell back");

    // no disable here: the antecedent spans the release edge itself
    a_strap_boot: assert property
        (@(posedge core_clk)
         !rst_b ##1 rst_b && external_boot_select_pin
         |=> ready_q)
        else $error("internal boot not ready");

    a_boot_read: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_MEM && !rst_b_prev_q
         && external_boot_select_pin
         |=> rdata == MEM_FINAL)
        else $error("first read after internal boot provisional");

    a_prog_word: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_PROG
         |=> rdata == PROG_VALUE)
        else $error("programming word wrong");

    a_supply_byte: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_PROG
         |=> rdata[7:0] == SUPPLY_LEVEL)
        else $error("supply level byte wrong");

    a_hv_level: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_PROG
         |=> rdata[15:8] == HV_LEVEL)
        else $error("high voltage level not zero");

    a_maker_pattern: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_MAKER
         |=> rdata[4:0] == MAKER_PATTERN)
        else $error("maker pattern wrong");

    a_chip_word: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_CHIP
         |=> rdata == {CHIP_CODE, REVISION})
        else $error("chip word wrong");

    // codes above fast flash are reserved and never reported once init is done
    a_type_code: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_MEM && init_ok
         |=> rdata[15:12] <= TYPE_FAST_FLASH)
        else $error("reserved memory type reported");

    a_size_field: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && addr == ADDR_MEM
         |=> rdata[11:0] == SIZE_FINAL)
        else $error("memory size field wrong");

    a_write_ignored: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         wr_en && !rd_en
         |=> $stable(rdata))
        else $error("write changed read data");

    a_unmapped_read: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en && !sel_hit
         |=> rdata == 16'h0000 && !addr_hit)
        else $error("unmapped read not zero");

    a_read_answer: assert property
        (@(posedge core_clk) disable iff (!rst_b)
         rd_en
         |=> rvalid && addr_hit == $past(sel_hit))
        else $error("read answer missing");

    // =========================================================
    // coverage
    c_poll_done: cover property (@(posedge core_clk) disable iff (!rst_b)
        rd_en && addr == ADDR_MEM && !ready_q ##[1:20] ready_q);

    c_ext_boot: cover property (@(posedge core_clk)
        !rst_b ##1 rst_b && !external_boot_select_pin);

    c_chip_read: cover property (@(posedge core_clk) disable iff (!rst_b)
        rd_en && addr == ADDR_CHIP);

    c_first_edge_read: cover property (@(posedge core_clk)
        rst_b && !rst_b_prev_q && rd_en);

    c_write_attempt: cover property (@(posedge core_clk) disable iff (!rst_b)
        wr_en && addr == ADDR_MAKER);
endmodule : device_identification_registers

// ---- test/testbench.sv ----
// self-checking bench for the identification register bank
`timescale 1ns/1ps
module testbench;
    import id_regs_pkg::*;
    // arbitrary neutral identity values
    localparam logic [10:0] MK = 11'h2b6;
    localparam logic [11:0] CH = 12'h6c3;
    localparam logic [3:0]  RV = 4'h2;
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        boot_pin = 1'b1;
    logic        init_done = 1'b0;
    logic        rd_en    = 1'b0;
    logic        wr_en    = 1'b0;
    logic [15:0] addr     = 16'h0000;
    logic [15:0] wdata    = 16'h0000;
    logic [15:0] rdata;
    logic        rvalid;
    logic        addr_hit;
    int          fail_count = 0;
    int          checks_done = 0;
    // =========================================================
    // design
    device_identification_registers #(.MAKER_CODE(MK), .CHIP_CODE(CH),
        .REVISION(RV)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .external_boot_select_pin(boot_pin), .flash_init_done(init_done),
        .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid), .addr_hit(addr_hit));
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    // =========================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic do_reset(input logic pin);
        @(posedge core_clk);
        boot_pin <= pin;
        rst_b    <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b    <= 1'b1;
    endtask : do_reset
    // one strobe cycle, answer checked the cycle after
    task automatic rd(input logic [15:0] a, input logic [15:0] exp,
                      input logic hit);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk({15'h0000, rvalid}, 16'h0001);
        chk({15'h0000, addr_hit}, {15'h0000, hit});
        chk(rdata, exp);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr
    // =========================================================
    // scenarios
    task automatic t_internal_boot;
        do_reset(1'b1);
        rd(ADDR_MEM, {TYPE_FAST_FLASH, SIZE_FINAL}, 1'b1);
        rd(ADDR_MAKER, {MK, MAKER_PATTERN}, 1'b1);
        rd(ADDR_CHIP, {CH, RV}, 1'b1);
        rd(ADDR_PROG, {HV_LEVEL, SUPPLY_LEVEL}, 1'b1);
        rd(16'hf076, 16'h0000, 1'b0);
        wr(ADDR_MEM, 16'h0000);
        wr(ADDR_MAKER, 16'hffff);
        rd(ADDR_MEM, MEM_FINAL, 1'b1);
        rd(ADDR_MAKER, {MK, MAKER_PATTERN}, 1'b1);
        $display("test internal boot done");
    endtask : t_internal_boot
    task automatic t_external_boot;
        do_reset(1'b0);
        rd(ADDR_MEM, MEM_PROVISION, 1'b1);
        rd(ADDR_PROG, PROG_VALUE, 1'b1);
        rd(ADDR_CHIP, {CH, RV}, 1'b1);
        rd(ADDR_MEM, MEM_PROVISION, 1'b1);
        // single pulse: ready must stick after it drops
        @(posedge core_clk);
        init_done <= 1'b1;
        rd_en     <= 1'b1;
        addr      <= ADDR_MEM;
        @(posedge core_clk);
        init_done <= 1'b0;
        #1;
        chk(rdata, MEM_PROVISION);
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, MEM_FINAL);
        rd(ADDR_MEM, MEM_FINAL, 1'b1);
        repeat (10) @(posedge core_clk);
        rd(ADDR_MEM, MEM_FINAL, 1'b1);
        $display("test external boot done");
    endtask : t_external_boot
    // read taken at the very first edge after release
    task automatic t_first_edge_read;
        do_reset(1'b1);
        rd_en <= 1'b1;
        addr  <= ADDR_MEM;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata, MEM_FINAL);
        do_reset(1'b0);
        rd_en <= 1'b1;
        addr  <= ADDR_MEM;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, MEM_PROVISION);
        $display("test first edge read done");
    endtask : t_first_edge_read
    // =========================================================
    // verdict and watchdog
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (2000) @(posedge core_clk);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        t_internal_boot();
        t_external_boot();
        t_first_edge_read();
        give_verdict();
    end
endmodule : testbench
